// *** pkg/mscc_pkg.sv ***
// Constants for the microstep status and chopper configuration block.
// Assumes a single 250 MHz system clock and the documented register port.
package mscc_pkg;

  // ==========================================================
  // Register port
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_MICROSTEP_POSITION    = 7'h36;
  localparam logic [ADDR_W-1:0] REG_PHASE_TABLE_CURRENTS  = 7'h37;
  localparam logic [ADDR_W-1:0] REG_CHOPPER_CONFIGURATION = 7'h38;

  // ==========================================================
  // Microstep counter and sine table
  localparam int CNT_W     = 10;
  localparam int CUR_W     = 9;
  localparam int QTR_LEN   = 256;
  localparam int QTR_SHIFT = 16;
  localparam logic [CUR_W-1:0] QTR_PEAK  = 9'h0f7;
  localparam logic [CUR_W-1:0] RST_PHASE_A_TABLE_CURRENT = QTR_PEAK;
  localparam logic [CUR_W-1:0] RST_PHASE_B_TABLE_CURRENT = 9'h000;
  localparam int PHASE_B_TABLE_CURRENT_LSB = 16;
  localparam int PHASE_A_TABLE_CURRENT_LSB = 0;

  // ==========================================================
  // Chopper configuration field positions
  localparam int F_SUPPLY_SHORT = 31;
  localparam int F_GROUND_SHORT = 30;
  localparam int F_DUAL_EDGE    = 29;
  localparam int F_INTERPOLATE  = 28;
  localparam int F_MICROSTEP_RESOLUTION_LSB     = 24;
  localparam int F_PASSIVE_FAST_DECAY_TIME_LSB     = 20;
  localparam int F_VHIGH_CHOP   = 19;
  localparam int F_VHIGH_FULL   = 18;
  localparam int F_TBL_LSB      = 15;
  localparam int F_CHOP_METHOD  = 14;
  localparam int F_FD_COMP_OFF  = 12;
  localparam int F_FD_MSB       = 11;
  localparam int F_HEND_LSB     = 7;
  localparam int F_HSTRT_LSB    = 4;
  localparam int F_OFF_TIME_SELECT_LSB     = 0;
  localparam logic [3:0] MICROSTEP_RESOLUTION_MAX = 4'h8;

  // Field reset values
  localparam logic [DATA_W-1:0] RST_INTERPOLATE = 32'h0000_0001;
  localparam logic [DATA_W-1:0] RST_PASSIVE_FAST_DECAY_TIME        = 32'h0000_0004;
  localparam logic [DATA_W-1:0] RST_TBL         = 32'h0000_0002;
  localparam logic [DATA_W-1:0] RST_HEND        = 32'h0000_0002;
  localparam logic [DATA_W-1:0] RST_HSTRT       = 32'h0000_0005;
  localparam logic [DATA_W-1:0] CFG_RST =
      (RST_INTERPOLATE << F_INTERPOLATE) | (RST_PASSIVE_FAST_DECAY_TIME << F_PASSIVE_FAST_DECAY_TIME_LSB) |
      (RST_TBL << F_TBL_LSB) | (RST_HEND << F_HEND_LSB) |
      (RST_HSTRT << F_HSTRT_LSB);
  // Bits 17 and 13 are unused and read zero
  localparam logic [DATA_W-1:0] CFG_MASK = 32'hfffd_dfff;

  // ==========================================================
  // Interpolation pacing
  localparam int CLK_NS          = 4;
  localparam int INTERP_TICK_NS  = 64;
  localparam int INTERP_DIV      = INTERP_TICK_NS / CLK_NS;
  localparam int DIV_W           = $clog2(INTERP_DIV);

endpackage : mscc_pkg

// *** pkg/mscc_table_if.sv ***
// Carries the table index and the two phase currents between modules.
// Assumes purely combinational lookup in one cycle.
interface mscc_table_if;
  logic [mscc_pkg::CNT_W-1:0] idx_b;
  logic [mscc_pkg::CUR_W-1:0] phase_a_table_current;
  logic [mscc_pkg::CUR_W-1:0] phase_b_table_current;

  modport lookup (input idx_b, output phase_a_table_current, output phase_b_table_current);
  modport user   (output idx_b, input phase_a_table_current, input phase_b_table_current);
endinterface : mscc_table_if

// *** hdl/mscc_sine_table.sv ***
// Sine lookup for both motor phases from one microstep index.
// Assumes the index is stable for one cycle; output is combinational.
module mscc_sine_table (
  mscc_table_if.lookup t    // Index in, phase currents out
);
  import mscc_pkg::*;

  // ==========================================================
  // Quarter wave, parabolic fit peaking at QTR_PEAK
  logic [7:0]       qtr [0:QTR_LEN];
  logic [CNT_W-1:0] idx [2];
  logic [CUR_W-1:0] cur [2];

  for (genvar i = 0; i <= QTR_LEN; i++) begin : g_qtr
    assign qtr[i] = 8'((i * (2 * QTR_LEN - i) * int'(QTR_PEAK))
                       >> QTR_SHIFT);
  end

  assign idx[0] = t.idx_b;
  assign idx[1] = t.idx_b + 10'(QTR_LEN);

  // ==========================================================
  // Fold full wave onto the quarter table
  for (genvar p = 0; p < 2; p++) begin : g_phase
    logic [8:0] addr;
    logic [7:0] mag;
    assign addr = idx[p][8] ? 9'(QTR_LEN) - {1'b0, idx[p][7:0]}
                            : {1'b0, idx[p][7:0]};
    assign mag  = qtr[addr];
    // Negative half waves in two's complement
    assign cur[p] = idx[p][9] ? 9'h000 - {1'b0, mag} : {1'b0, mag};
  end

  assign t.phase_b_table_current = cur[0];
  assign t.phase_a_table_current = cur[1];

endmodule // mscc_sine_table

// *** hdl/mscc_top.sv ***
// Microstep position counter, phase table currents and chopper config.
// Assumes step and direction inputs synchronous to i_clk_sys, and a
// simple register port with one-cycle read and write strobes.
module mscc_top
  import mscc_pkg::*;
(
  input  logic                         i_clk_sys,    // System clock
  input  logic                         i_reset,      // Async reset, high
  input  logic                         i_step,       // Step input level
  input  logic                         i_dir,        // 1 counts up
  input  logic [mscc_pkg::ADDR_W-1:0]  i_reg_addr,   // Register address
  input  logic                         i_reg_wr,     // Write strobe
  input  logic                         i_reg_rd,     // Read strobe
  input  logic [mscc_pkg::DATA_W-1:0]  i_reg_wdata,  // Write data
  output logic [mscc_pkg::DATA_W-1:0]  o_reg_rdata,  // Read data
  output logic                         o_reg_rvalid, // Read data valid
  output logic [mscc_pkg::CNT_W-1:0]   o_microstep_position_count, // Index
  output logic [mscc_pkg::CUR_W-1:0]   o_phase_a_table_current,    // Phase A
  output logic [mscc_pkg::CUR_W-1:0]   o_phase_b_table_current,    // Phase B
  output logic [mscc_pkg::DATA_W-1:0]  o_chopper_config  // Config word
);
  import mscc_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [DATA_W-1:0] cfg;
    logic [CNT_W-1:0]  count;
    logic [CUR_W-1:0]  phase_a_table_current;
    logic [CUR_W-1:0]  phase_b_table_current;
    logic [8:0]        pend;
    logic              pend_dir;
    logic              step_q;
    logic [DIV_W-1:0]  div;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
  } mscc_state_s;

  mscc_state_s s;
  mscc_state_s next_s;

  mscc_table_if blank_time_select ();

  mscc_sine_table u_table (
    .t (blank_time_select)
  );

  logic             step_now;
  logic             tick;
  logic             valid_res;
  logic             cfg_intpol;
  logic             cfg_dedge;
  logic [3:0]       cfg_microstep_resolution;
  logic [CNT_W-1:0] step_w;
  logic [CNT_W-1:0] base;

  assign cfg_intpol = s.cfg[F_INTERPOLATE];
  assign cfg_dedge  = s.cfg[F_DUAL_EDGE];
  assign cfg_microstep_resolution   = s.cfg[F_MICROSTEP_RESOLUTION_LSB +: 4];
  assign blank_time_select.idx_b  = s.count;

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    // Dual edge lets a slow step source reach full speed
    step_now = cfg_dedge ? (i_step ^ s.step_q)
                         : (i_step & ~s.step_q);
    next_s.step_q = i_step;
    tick = (s.div == DIV_W'(INTERP_DIV - 1));
    next_s.div = tick ? '0 : s.div + 1'b1;
    valid_res = (cfg_microstep_resolution <= MICROSTEP_RESOLUTION_MAX);
    step_w = valid_res ? (10'h001 << cfg_microstep_resolution) : 10'h000;
    // Leftover interpolation lands at once so no step is lost
    base = s.pend_dir ? s.count + 10'(s.pend)
                      : s.count - 10'(s.pend);

    if (step_now && valid_res) begin
      if (cfg_intpol) begin
        next_s.count    = base;
        next_s.pend     = 9'(step_w);
        next_s.pend_dir = i_dir;
      end else begin
        next_s.count = i_dir ? base + step_w : base - step_w;
        next_s.pend  = '0;
      end
    end else if (s.pend != '0 && tick) begin
      next_s.count = s.pend_dir ? s.count + 10'h001
                                : s.count - 10'h001;
      next_s.pend  = s.pend - 9'h001;
    end

    next_s.phase_a_table_current = blank_time_select.phase_a_table_current;
    next_s.phase_b_table_current = blank_time_select.phase_b_table_current;

    // Only the configuration word is writable
    if (i_reg_wr && i_reg_addr == REG_CHOPPER_CONFIGURATION) begin
      next_s.cfg = i_reg_wdata & CFG_MASK;
    end

    next_s.rvalid = i_reg_rd;
    next_s.rdata  = '0;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        REG_MICROSTEP_POSITION:
          next_s.rdata = {22'h00_0000, s.count};
        REG_PHASE_TABLE_CURRENTS:
          next_s.rdata = {7'h00, s.phase_b_table_current, 7'h00, s.phase_a_table_current};
        REG_CHOPPER_CONFIGURATION:
          next_s.rdata = s.cfg;
        default:
          next_s.rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      s        <= '0;
      s.cfg    <= CFG_RST;
      s.phase_a_table_current  <= RST_PHASE_A_TABLE_CURRENT;
      s.phase_b_table_current  <= RST_PHASE_B_TABLE_CURRENT;
    end else begin
      s <= next_s;
    end
  end

  assign o_reg_rdata                = s.rdata;
  assign o_reg_rvalid               = s.rvalid;
  assign o_microstep_position_count = s.count;
  assign o_phase_a_table_current    = s.phase_a_table_current;
  assign o_phase_b_table_current    = s.phase_b_table_current;
  assign o_chopper_config           = s.cfg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_step_width_move: assert property (
    (step_now && valid_res && !cfg_intpol && s.pend == '0) |=>
      (s.count == ($past(i_dir) ? $past(s.count) + $past(step_w)
                                : $past(s.count) - $past(step_w))))
    else $error("count did not move by step width");

  a_bad_res_hold: assert property (
    (step_now && !valid_res && s.pend == '0) |=> $stable(s.count))
    else $error("unused resolution moved the counter");

  a_interp_unit: assert property (
    (cfg_intpol && step_now && valid_res) |=>
      (s.pend == 9'($past(step_w)) && s.pend_dir == $past(i_dir)))
    else $error("interpolation did not load the step width");

  a_interp_single: assert property (
    (s.pend != '0 && tick && !step_now) |=>
      (s.count - $past(s.count) == 10'h001 ||
       $past(s.count) - s.count == 10'h001))
    else $error("interpolated move was not one microstep");

  a_zero_currents: assert property (
    (s.count == '0) ##1 (s.count == '0) |=>
      (s.phase_b_table_current == RST_PHASE_B_TABLE_CURRENT && s.phase_a_table_current == QTR_PEAK))
    else $error("phase currents wrong at index zero");

  a_quadrature: assert property (
    (s.count == 10'(QTR_LEN)) ##1 (s.count == 10'(QTR_LEN)) |=>
      (s.phase_b_table_current == QTR_PEAK && s.phase_a_table_current == RST_PHASE_B_TABLE_CURRENT))
    else $error("phase A not a quarter wave ahead");

  a_cfg_unused_zero: assert property (
    s.cfg[17] == 1'b0 && s.cfg[13] == 1'b0)
    else $error("unused configuration bit set");

  a_cfg_write: assert property (
    (i_reg_wr && i_reg_addr == REG_CHOPPER_CONFIGURATION) |=>
      (s.cfg == ($past(i_reg_wdata) & CFG_MASK)))
    else $error("configuration write not stored");

  a_count_readback: assert property (
    (i_reg_rd && i_reg_addr == REG_MICROSTEP_POSITION) |=>
      (o_reg_rvalid && o_reg_rdata == {22'h00_0000, $past(s.count)}))
    else $error("counter readback wrong");

  a_ro_regs_fixed: assert property (
    (i_reg_wr && i_reg_addr != REG_CHOPPER_CONFIGURATION) |=>
      $stable(s.cfg))
    else $error("write to read-only register changed config");

  c_wrap_up: cover property (
    (s.count == 10'h3ff && step_now && i_dir && !cfg_intpol) ##1
      (s.count == 10'h000));
  c_interp_done: cover property (
    (cfg_intpol && step_now) ##[1:300] (s.pend == '0));
  c_cfg_write: cover property (
    i_reg_wr && i_reg_addr == REG_CHOPPER_CONFIGURATION);
  c_dual_edge: cover property (cfg_dedge && step_now && !i_step);

endmodule // mscc_top

// *** tb/mscc_motor_model.sv ***
// Stand-in for the two motor phases behind the bridges.
// Assumes phase currents arrive registered on the system clock.
module mscc_motor_model
  import mscc_pkg::*;
(
  input  wire logic             i_clk_sys, // System clock
  input  wire logic             i_reset,   // Async reset, high
  input  wire logic [CUR_W-1:0] i_phase_a_table_current,   // Phase A drive
  input  wire logic [CUR_W-1:0] i_phase_b_table_current,   // Phase B drive
  output logic      [15:0]      o_changes  // Drive updates seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2*CUR_W-1:0] last;
  // A winding only reacts when its drive level moves
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      last      <= '0;
      o_changes <= '0;
    end else begin
      last <= {i_phase_a_table_current, i_phase_b_table_current};
      if (last !== {i_phase_a_table_current, i_phase_b_table_current}) o_changes <= o_changes + 16'h0001;
    end
  end
endmodule // mscc_motor_model

// *** tb/mscc_top_test.sv ***
// Self-checking bench for the microstep status and chopper block.
// Assumes register port strobes of one cycle and read data a cycle later.
module mscc_top_test;
  import mscc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BASE = 32'h0041_0150;
  logic              i_clk_sys = 1'b0;
  logic              i_reset   = 1'b1;
  logic              i_step    = 1'b0;
  logic              i_dir     = 1'b1;
  logic [ADDR_W-1:0] i_reg_addr  = '0;
  logic              i_reg_wr    = 1'b0;
  logic              i_reg_rd    = 1'b0;
  logic [DATA_W-1:0] i_reg_wdata = '0;
  logic [DATA_W-1:0] o_reg_rdata, o_chopper_config;
  logic              o_reg_rvalid;
  logic [CNT_W-1:0]  cnt;
  logic [CUR_W-1:0]  phase_a_table_current, phase_b_table_current;
  logic [15:0]       changes;
  logic [31:0]       exp_q[$];
  logic [31:0]       w;
  int                miscompares = 0;
  int                samples_checked = 0;
  int                e;
  int                n;
  always #2 i_clk_sys = ~i_clk_sys;
  mscc_top DUT (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_step(i_step),
    .i_dir(i_dir), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_microstep_position_count(cnt), .o_phase_a_table_current(phase_a_table_current),
    .o_phase_b_table_current(phase_b_table_current), .o_chopper_config(o_chopper_config));
  mscc_motor_model motor (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_phase_a_table_current(phase_a_table_current), .i_phase_b_table_current(phase_b_table_current), .o_changes(changes));
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Read data is judged by its own watcher, in request order
  always @(negedge i_clk_sys) begin
    if (o_reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(o_reg_rdata, 32'hdead_0000);
      else chk(o_reg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    miscompares++;
    test_done();
  end
  // ==========================================================
  // Drivers
  task automatic rd(input logic [6:0] a, input logic [31:0] x);
    @(negedge i_clk_sys);
    i_reg_addr = a;
    i_reg_rd   = 1'b1;
    exp_q.push_back(x);
    @(negedge i_clk_sys);
    i_reg_rd = 1'b0;
    @(negedge i_clk_sys);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge i_clk_sys);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
  endtask
  task automatic stp(input logic l);
    @(negedge i_clk_sys);
    i_step = l;
    repeat (3) @(negedge i_clk_sys);
  endtask
  task automatic mv(input logic [3:0] r, input logic d, input int x);
    wr(REG_CHOPPER_CONFIGURATION, BASE | {4'h0, r, 24'h0});
    i_dir = d;
    stp(1'b1);
    stp(1'b0);
    chk(32'(cnt), 32'(x));
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hc484));
    repeat (5) @(negedge i_clk_sys);
    i_reset = 1'b0;
    chk(o_chopper_config, 32'h1041_0150);
    rd(REG_MICROSTEP_POSITION, 32'h0000_0000);
    rd(REG_PHASE_TABLE_CURRENTS, 32'h0000_00f7);
    rd(REG_CHOPPER_CONFIGURATION, 32'h1041_0150);
    w = $urandom();
    wr(REG_CHOPPER_CONFIGURATION, w);
    rd(REG_CHOPPER_CONFIGURATION, w & 32'hfffd_dfff);
    wr(REG_MICROSTEP_POSITION, 32'h0000_03ff);
    rd(REG_MICROSTEP_POSITION, 32'h0000_0000);
    rd(7'h40, 32'h0000_0000);
    // Every resolution code once, then an unused code
    e = 0;
    for (int r = 0; r < 10; r++) begin
      if (r < 9) e = (e + (1 << r)) % 1024;
      mv(4'(r), 1'b1, e);
    end
    mv(4'h0, 1'b1, 512);
    mv(4'h8, 1'b0, 256);
    chk({phase_b_table_current, phase_a_table_current}, {9'h0f7, 9'h000});
    // Host parks at index zero before any table rework
    mv(4'h8, 1'b0, 0);
    mv(4'h8, 1'b0, 768);
    rd(REG_PHASE_TABLE_CURRENTS, 32'h0109_0000);
    // Both step edges count once dual edge is on
    wr(REG_CHOPPER_CONFIGURATION, BASE | 32'h2800_0000);
    i_dir = 1'b1;
    stp(1'b1);
    chk(32'(cnt), 32'h0000_0000);
    stp(1'b0);
    chk(32'(cnt), 32'h0000_0100);
    // Interpolated full step walks single microsteps
    wr(REG_CHOPPER_CONFIGURATION, BASE | 32'h1800_0000);
    stp(1'b1);
    n = 0;
    while (cnt === 10'h100 && n < 40) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk(32'(cnt), 32'h0000_0101);
    n = 0;
    while (cnt !== 10'h200 && n < 4500) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk(32'(cnt), 32'h0000_0200);
    chk(32'(changes > 16'h0000), 32'h0000_0001);
    rd(REG_MICROSTEP_POSITION, 32'h0000_0200);
    repeat (3) @(negedge i_clk_sys);
    test_done();
  end
endmodule // mscc_top_test
